// ==== common/prc_pkg.sv ====
// constants for the peer-to-peer receiver and correlator config bank
package prc_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_ENV  = 6'h0B;
    localparam logic [5:0] IDX_COR1 = 6'h0C;
    localparam logic [5:0] IDX_COR2 = 6'h0D;
    localparam int         ADDR_W   = 8;
    localparam int         DATA_W   = 32;
    // reset values
    localparam logic [7:0] RST_ENV  = 8'h0C;
    localparam logic [7:0] RST_COR1 = 8'h93;
    localparam logic [7:0] RST_COR2 = 8'h00;
    localparam logic [7:0] COR2_MASK = 8'h03;
    // field positions, envelope register
    localparam int B_ONOFF_KEYING_FAST_DECAY  = 7;
    localparam int B_OOK_TC  = 5;
    localparam int B_OOK_THD = 3;
    localparam int B_ASK_TC  = 1;
    localparam int B_ASK_THD = 0;
    // field positions, correlator register 1
    localparam int B_AGC_LINK = 7;
    localparam int B_SRC_HOLD = 6;
    localparam int B_SQ_STEP  = 5;
    localparam int B_SUM_EN   = 4;
    localparam int B_START    = 3;
    localparam int B_SLICER   = 2;
    localparam int B_COLL_HI  = 1;
    localparam int B_COLL_LO  = 0;
    // field positions, correlator register 2
    localparam int B_SLEEP_X  = 1;
    localparam int B_STREAM   = 0;
    // time constants in tenths of a microsecond
    localparam logic [6:0] OOK_TC_00 = 7'd14;
    localparam logic [6:0] OOK_TC_01 = 7'd10;
    localparam logic [6:0] OOK_TC_10 = 7'd6;
    localparam logic [6:0] OOK_TC_11 = 7'd2;
    localparam logic [6:0] ASK_TC_00 = 7'd84;
    localparam logic [6:0] ASK_TC_01 = 7'd68;
    localparam logic [6:0] ASK_TC_10 = 7'd44;
    localparam logic [6:0] ASK_TC_11 = 7'd24;
    // thresholds in percent
    localparam logic [6:0] OOK_LO_BASE = 7'd55;
    localparam logic [6:0] OOK_HI_BASE = 7'd80;
    localparam logic [6:0] OOK_LO_STEP = 7'd10;
    localparam logic [6:0] OOK_HI_STEP = 7'd5;
    localparam logic [6:0] COLL_00 = 7'd16;
    localparam logic [6:0] COLL_01 = 7'd28;
    localparam logic [6:0] COLL_10 = 7'd41;
    localparam logic [6:0] COLL_11 = 7'd53;
    localparam logic [6:0] END_LVL_FULL = 7'd100;
    localparam logic [6:0] END_LVL_LOW  = 7'd66;
    localparam logic [6:0] ASK_THD_0 = 7'd97;
    localparam logic [6:0] ASK_THD_1 = 7'd95;
    // bpsk pilot pulse counts
    localparam logic [5:0] START_106_S = 6'd17;
    localparam logic [5:0] START_HI_S  = 6'd9;
    localparam logic [5:0] START_106_L = 6'd33;
    localparam logic [5:0] START_HI_L  = 6'd17;
    // sleep timing
    localparam int CLK_MHZ      = 50;
    localparam int T_IDLE_US    = 18;
    localparam int T_WAKE_S_US  = 18;
    localparam int T_WAKE_L_US  = 42;
    localparam int IDLE_CYC     = T_IDLE_US * CLK_MHZ;
    localparam int WAKE_S_CYC   = T_WAKE_S_US * CLK_MHZ;
    localparam int WAKE_L_CYC   = T_WAKE_L_US * CLK_MHZ;
    localparam int CNT_W        = 12;
    // reception standard
    typedef enum logic [2:0]
    {
        STD_ISO_A,
        STD_ISO_B,
        STD_F212,
        STD_F424,
        STD_V_STREAM,
        STD_OTHER
    } prc_std_e;
endpackage

// ==== logic/prc_cfg_regs.sv ====
// peer-to-peer receiver and correlator configuration register bank
//
// What this block does
// [RULE_01] OOK time constant 1.4/1.0/0.6/0.2 us
// [RULE_02] ASK time constant 8.4/6.8/4.4/2.4 us
// [RULE_03] OOK threshold depends on OOK time constant
// [RULE_04] AGC link forces equal AM/PM gain
// [RULE_05] ISO-A 106k: collision level from slicer
// [RULE_06] BPSK: same bit stops phase correction
// [RULE_07] summation bit sums AM and PM
// [RULE_08] start length selects 17/9 or 33/17
// [RULE_09] slicer speed or reference time constant
// [RULE_10] collision level 16/28/41/53 percent
// [RULE_11] BPSK end detection level 100/66 percent
// [RULE_12] BPSK end detector enable bit
// [RULE_13] BPSK meaning for A high rate, B
// [RULE_14] sleep after 18 us without pulse
// [RULE_15] sleep exit by timer or rx_on
// [RULE_16] software sets stream bit for 424k stream
// [RULE_17] reserved bits read zero, no effect
// [RULE_18] defaults on reset, fields driven continuously; outputs other than waitrequest reset to zero, decoded defaults follow one clock later

module prc_cfg_regs
(
    input  wire logic                       ref_clk,       // 50 MHz clock
    input  wire logic                       rst_b,         // async reset, low

    // avalon-mm slave
    input  wire logic [prc_pkg::ADDR_W-1:0] address,       // byte address
    input  wire logic                       read,          // read request
    input  wire logic                       write,         // write request
    input  wire logic [prc_pkg::DATA_W-1:0] writedata,     // write data
    input  wire logic [3:0]                 byteenable,    // byte lanes
    output logic [prc_pkg::DATA_W-1:0]      readdata,      // read data
    output logic                            waitrequest,   // stall

    // receiver context
    input  wire prc_pkg::prc_std_e          std_sel,       // reception standard
    input  wire logic                       rate_106,      // 106 kb/s rate
    input  wire logic                       corr_pulse,    // correlator pulse
    input  wire logic                       rx_on,         // receiver on

    // raw fields
    output logic                            onoff_keying_fast_decay, // ook decay
    output logic                            squelch_step_select,     // squelch
    output logic                            subcarrier_stream_mode,  // 424k stream
    output logic                            amp_keying_thd_sel,      // ask thd bit

    // decoded controls
    output logic [6:0]                      ook_tc_tenth_us, // ook tc, 0.1 us
    output logic [6:0]                      ask_tc_tenth_us, // ask tc, 0.1 us
    output logic [6:0]                      ook_thd_pct,     // ook threshold
    output logic [6:0]                      ask_thd_pct,     // ask threshold

    output logic                            agc_linked,      // equal am/pm gain
    output logic                            channel_sum,     // summation mode

    output logic                            coll_from_slicer,// coll = slicer
    output logic [6:0]                      coll_thd_pct,    // coll threshold
    output logic                            phase_hold,      // stop phase corr
    output logic [5:0]                      start_pulses,    // pilot pulses

    output logic                            fast_slicer,     // fast slicer
    output logic                            ref_tc_long,     // 1.5x ref tc
    output logic [6:0]                      end_level_pct,   // end det level
    output logic                            end_detect_en,   // end detector on

    output logic                            corr_sleep       // correlator asleep
);
    // register file
    logic [7:0]  env_r;
    logic [7:0]  cor1_r;
    logic [7:0]  cor2_r;

    // bus state
    logic                       wait_r;
    logic [prc_pkg::DATA_W-1:0] rdata_r;

    // bus decode
    logic [5:0]  word_idx;

    logic        req;
    logic        take;

    logic        hit_env;
    logic        hit_cor1;
    logic        hit_cor2;

    logic        lane0;

    logic        wr_env;
    logic        wr_cor1;
    logic        wr_cor2;

    logic [7:0]  rd_byte;
    logic [7:0]  wbyte;

    logic [7:0]  env_nxt;
    logic [7:0]  cor1_nxt;
    logic [7:0]  cor2_nxt;

    assign word_idx = address[prc_pkg::ADDR_W-1:2];

    assign req      = read || write;
    assign take     = req && !wait_r;

    assign hit_env  = (word_idx == prc_pkg::IDX_ENV);
    assign hit_cor1 = (word_idx == prc_pkg::IDX_COR1);
    assign hit_cor2 = (word_idx == prc_pkg::IDX_COR2);

    assign lane0    = byteenable[0];
    assign wbyte    = writedata[7:0];

    assign wr_env   = take && write && lane0 && hit_env;
    assign wr_cor1  = take && write && lane0 && hit_cor1;
    assign wr_cor2  = take && write && lane0 && hit_cor2;

    // unmapped addresses read zero; reserved bits are never stored
    assign rd_byte  = hit_env  ? env_r  :
                      hit_cor1 ? cor1_r :
                      hit_cor2 ? cor2_r : 8'h00;

    assign env_nxt  = wr_env  ? wbyte : env_r;
    assign cor1_nxt = wr_cor1 ? wbyte : cor1_r;
    assign cor2_nxt = wr_cor2 ? (wbyte & prc_pkg::COR2_MASK) : cor2_r; // [RULE_17]

    // one wait cycle, then a single acknowledge cycle
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wait_r  <= 1'b1;
            rdata_r <= '0;
        end
        else
        begin
            wait_r <= !(req && wait_r);
            if (req && wait_r && read)
            begin
                rdata_r <= {24'h000000, rd_byte};
            end
        end
    end

    assign waitrequest = wait_r;
    assign readdata    = rdata_r;

    // configuration registers
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            env_r  <= prc_pkg::RST_ENV;   // [RULE_18]
            cor1_r <= prc_pkg::RST_COR1;  // [RULE_18]
            cor2_r <= prc_pkg::RST_COR2;  // [RULE_18]
        end
        else
        begin
            env_r  <= env_nxt;
            cor1_r <= cor1_nxt;
            cor2_r <= cor2_nxt;
        end
    end

    // field extraction
    logic [1:0]  ook_tc_code;
    logic [1:0]  ook_thd_code;
    logic [1:0]  ask_tc_code;
    logic [1:0]  coll_code;

    logic        bpsk_mode;
    logic        iso_a_106;

    assign ook_tc_code  = env_r[prc_pkg::B_OOK_TC +: 2];
    assign ook_thd_code = env_r[prc_pkg::B_OOK_THD +: 2];
    assign ask_tc_code  = env_r[prc_pkg::B_ASK_TC +: 2];

    assign coll_code    = cor1_r[prc_pkg::B_COLL_HI -: 2];

    // dual-purpose bits take the bpsk meaning for A high rate and all B
    assign iso_a_106 = (std_sel == prc_pkg::STD_ISO_A) && rate_106;
    assign bpsk_mode = ((std_sel == prc_pkg::STD_ISO_A) && !rate_106) ||
                       (std_sel == prc_pkg::STD_ISO_B);  // [RULE_13]

    // decoded values
    logic [6:0]  ook_tc_val;
    logic [6:0]  ask_tc_val;

    logic [6:0]  ook_thd_val;
    logic [6:0]  ook_lo_step;
    logic [6:0]  ook_hi_step;

    logic [6:0]  coll_val;

    logic [5:0]  start_val;

    logic        src_bit;
    logic        slc_bit;

    always_comb
    begin
        unique case (ook_tc_code)  // [RULE_01]
            2'b00:   ook_tc_val = prc_pkg::OOK_TC_00;
            2'b01:   ook_tc_val = prc_pkg::OOK_TC_01;
            2'b10:   ook_tc_val = prc_pkg::OOK_TC_10;
            2'b11:   ook_tc_val = prc_pkg::OOK_TC_11;
        endcase
    end

    always_comb
    begin
        unique case (ask_tc_code)  // [RULE_02]
            2'b00:   ask_tc_val = prc_pkg::ASK_TC_00;
            2'b01:   ask_tc_val = prc_pkg::ASK_TC_01;
            2'b10:   ask_tc_val = prc_pkg::ASK_TC_10;
            2'b11:   ask_tc_val = prc_pkg::ASK_TC_11;
        endcase
    end

    always_comb
    begin
        unique case (coll_code)  // [RULE_10]
            2'b00:   coll_val = prc_pkg::COLL_00;
            2'b01:   coll_val = prc_pkg::COLL_01;
            2'b10:   coll_val = prc_pkg::COLL_10;
            2'b11:   coll_val = prc_pkg::COLL_11;
        endcase
    end

    // threshold steps down from a base set by the time constant code
    assign ook_lo_step = 7'(ook_thd_code * prc_pkg::OOK_LO_STEP);
    assign ook_hi_step = 7'(ook_thd_code * prc_pkg::OOK_HI_STEP);

    assign ook_thd_val = (ook_tc_code == 2'b00) ?
                         (prc_pkg::OOK_LO_BASE - ook_lo_step) :
                         (prc_pkg::OOK_HI_BASE - ook_hi_step);  // [RULE_03]

    assign start_val = cor1_r[prc_pkg::B_START] ?
                       (rate_106 ? prc_pkg::START_106_L : prc_pkg::START_HI_L) :
                       (rate_106 ? prc_pkg::START_106_S : prc_pkg::START_HI_S); // [RULE_08]

    assign src_bit = cor1_r[prc_pkg::B_SRC_HOLD];
    assign slc_bit = cor1_r[prc_pkg::B_SLICER];

    // registered outputs
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            onoff_keying_fast_decay <= 1'b0;
            squelch_step_select     <= 1'b0;
            subcarrier_stream_mode  <= 1'b0;
            amp_keying_thd_sel      <= 1'b0;

            ook_tc_tenth_us         <= '0;
            ask_tc_tenth_us         <= '0;
            ook_thd_pct             <= '0;
            ask_thd_pct             <= '0;
        end
        else
        begin
            onoff_keying_fast_decay <= env_r[prc_pkg::B_ONOFF_KEYING_FAST_DECAY];   // [RULE_18]
            squelch_step_select     <= cor1_r[prc_pkg::B_SQ_STEP];
            subcarrier_stream_mode  <= cor2_r[prc_pkg::B_STREAM];  // [RULE_16]
            amp_keying_thd_sel      <= env_r[prc_pkg::B_ASK_THD];

            ook_tc_tenth_us         <= ook_tc_val;   // [RULE_01]
            ask_tc_tenth_us         <= ask_tc_val;   // [RULE_02]
            ook_thd_pct             <= ook_thd_val;  // [RULE_03]
            ask_thd_pct             <= env_r[prc_pkg::B_ASK_THD] ?
                                       prc_pkg::ASK_THD_1 : prc_pkg::ASK_THD_0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            agc_linked       <= 1'b0;
            channel_sum      <= 1'b0;
            coll_from_slicer <= 1'b0;
            coll_thd_pct     <= '0;

            phase_hold       <= 1'b0;
            start_pulses     <= '0;
        end
        else
        begin
            agc_linked       <= cor1_r[prc_pkg::B_AGC_LINK];  // [RULE_04]
            channel_sum      <= cor1_r[prc_pkg::B_SUM_EN];    // [RULE_07]
            coll_from_slicer <= iso_a_106 && src_bit;          // [RULE_05]
            coll_thd_pct     <= coll_val;                      // [RULE_10]

            phase_hold       <= bpsk_mode && src_bit;          // [RULE_06]
            start_pulses     <= start_val;                     // [RULE_08]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fast_slicer   <= 1'b0;
            ref_tc_long   <= 1'b0;

            end_level_pct <= '0;
            end_detect_en <= 1'b0;
        end
        else
        begin
            fast_slicer   <= iso_a_106 && slc_bit;   // [RULE_09]
            ref_tc_long   <= bpsk_mode && slc_bit;   // [RULE_09]

            end_level_pct <= cor1_r[prc_pkg::B_COLL_HI] ?
                             prc_pkg::END_LVL_LOW : prc_pkg::END_LVL_FULL; // [RULE_11]
            end_detect_en <= bpsk_mode && cor1_r[prc_pkg::B_COLL_LO]; // [RULE_12]
        end
    end

    // sleep control
    logic sleep_w;

    prc_sleep_ctl u_sleep
    (
        .ref_clk      (ref_clk),
        .rst_b        (rst_b),
        .corr_pulse   (corr_pulse),
        .rx_on        (rx_on),
        .exit_rx_only (cor2_r[prc_pkg::B_SLEEP_X]),  // [RULE_15]
        .std_sel      (std_sel),
        .sleep        (sleep_w)
    );

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            corr_sleep <= 1'b0;
        end
        else
        begin
            corr_sleep <= sleep_w;  // [RULE_14]
        end
    end
endmodule

// ==== logic/prc_sleep_ctl.sv ====
// correlator sleep controller: idle entry, timer or receiver-on exit
module prc_sleep_ctl
(
    input  wire logic               ref_clk,     // system clock
    input  wire logic               rst_b,       // async reset, low
    input  wire logic               corr_pulse,  // correlator output pulse
    input  wire logic               rx_on,       // receiver on
    input  wire logic               exit_rx_only,// sleep ends on rx_on only
    input  wire prc_pkg::prc_std_e  std_sel,     // reception standard
    output logic                    sleep        // correlator asleep
);
    typedef enum logic {S_AWAKE, S_SLEEP} prc_slp_e;

    prc_slp_e                       st_r;
    prc_slp_e                       st_nxt;
    logic [prc_pkg::CNT_W-1:0]      cnt_r;
    logic [prc_pkg::CNT_W-1:0]      cnt_nxt;
    logic                           long_wake;
    logic [prc_pkg::CNT_W-1:0]      wake_lim;
    logic [prc_pkg::CNT_W-1:0]      idle_lim;

    assign long_wake = (std_sel == prc_pkg::STD_V_STREAM) ||
                       (std_sel == prc_pkg::STD_F212);
    assign wake_lim  = long_wake ?
                       prc_pkg::CNT_W'(prc_pkg::WAKE_L_CYC - 1) :
                       prc_pkg::CNT_W'(prc_pkg::WAKE_S_CYC - 1);
    assign idle_lim  = prc_pkg::CNT_W'(prc_pkg::IDLE_CYC - 1);
    assign sleep     = (st_r == S_SLEEP);

    always_comb
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r + 1'b1;
        unique case (st_r)
            S_AWAKE:
            begin
                if (corr_pulse)
                begin
                    cnt_nxt = '0;
                end
                else if (cnt_r == idle_lim)
                begin
                    st_nxt  = S_SLEEP;  // [RULE_14]
                    cnt_nxt = '0;
                end
            end
            S_SLEEP:
            begin
                if (exit_rx_only)
                begin
                    cnt_nxt = '0;
                    if (rx_on)
                    begin
                        st_nxt = S_AWAKE;  // [RULE_15]
                    end
                end
                else if (cnt_r == wake_lim)
                begin
                    st_nxt  = S_AWAKE;  // [RULE_15]
                    cnt_nxt = '0;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r  <= S_AWAKE;
            cnt_r <= '0;
        end
        else
        begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ==== testbench/prc_cfg_checker.sv ====
// assertion checker for the receiver and correlator config bank
module prc_cfg_checker
(
    input wire logic              ref_clk,          // clock
    input wire logic              rst_b,            // reset, low
    input wire logic [7:0]        address,          // byte address
    input wire logic              read,             // read request
    input wire logic              write,            // write request
    input wire logic [31:0]       readdata,         // read data
    input wire logic              waitrequest,      // stall
    input wire prc_pkg::prc_std_e std_sel,          // standard
    input wire logic              rate_106,         // 106k rate
    input wire logic              corr_pulse,       // correlator pulse
    input wire logic [6:0]        ook_tc_tenth_us,  // ook tc
    input wire logic [6:0]        ook_thd_pct,      // ook threshold
    input wire logic              coll_from_slicer, // collision source
    input wire logic [5:0]        start_pulses,     // pilot count
    input wire logic              end_detect_en,    // end detector
    input wire logic              corr_sleep        // asleep
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // cycles without a pulse while awake
    logic [11:0] quiet_r;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            quiet_r <= 12'h000;
        else if (corr_pulse || corr_sleep)
            quiet_r <= 12'h000;
        else if (quiet_r != 12'hFFF)
            quiet_r <= quiet_r + 12'h001;
    end

    a_wait_single:
        assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low twice");
    a_req_answered:
        assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not acknowledged");
    a_resv_zero:
        assert property (read && !waitrequest && address[7:2] == prc_pkg::IDX_COR2
            |-> readdata[31:2] == 30'h0)
        else $error("reserved bits read nonzero");
    a_ook_thd_pair:
        assert property (ook_tc_tenth_us != 7'h00 |-> (ook_tc_tenth_us == 7'h0E)
            == (ook_thd_pct inside {7'h37, 7'h2D, 7'h23, 7'h19}))
        else $error("ook threshold set mismatch");
    a_slicer_gate:
        assert property (coll_from_slicer
            |-> $past(std_sel) == prc_pkg::STD_ISO_A && $past(rate_106))
        else $error("collision source active outside iso-a 106k");
    a_end_gate:
        assert property (end_detect_en |-> $past(std_sel) == prc_pkg::STD_ISO_B
            || ($past(std_sel) == prc_pkg::STD_ISO_A && !$past(rate_106)))
        else $error("end detector active outside bpsk");
    a_start_count:
        assert property (start_pulses inside {6'h09, 6'h21}
            |-> $past(rate_106) == (start_pulses == 6'h21))
        else $error("start length does not match bit rate");
    a_sleep_entry:
        assert property ($rose(corr_sleep) |-> quiet_r >= 12'd898 && quiet_r <= 12'd904)
        else $error("sleep entered at wrong idle time");
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the receiver and correlator config bank
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic              ref_clk, rst_b, read, write, rate_106, corr_pulse, rx_on, waitrequest;
    logic [7:0]        address, e, c, s;
    logic [31:0]       writedata, readdata, q;
    logic [3:0]        byteenable;
    prc_pkg::prc_std_e std_sel;
    logic              onoff_keying_fast_decay, squelch_step_select, subcarrier_stream_mode;
    logic              amp_keying_thd_sel, agc_linked, channel_sum, coll_from_slicer, phase_hold;
    logic              fast_slicer, ref_tc_long, end_detect_en, corr_sleep;
    logic [6:0]        ook_tc_tenth_us, ask_tc_tenth_us, ook_thd_pct, ask_thd_pct;
    logic [6:0]        coll_thd_pct, end_level_pct;
    logic [5:0]        start_pulses;
    int                errors, n_tests, cycles, n;
    integer            seed;

    prc_cfg_regs uut
    (
        .ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .std_sel(std_sel), .rate_106(rate_106),
        .corr_pulse(corr_pulse), .rx_on(rx_on),
        .onoff_keying_fast_decay(onoff_keying_fast_decay),
        .squelch_step_select(squelch_step_select),
        .subcarrier_stream_mode(subcarrier_stream_mode),
        .amp_keying_thd_sel(amp_keying_thd_sel), .ook_tc_tenth_us(ook_tc_tenth_us),
        .ask_tc_tenth_us(ask_tc_tenth_us), .ook_thd_pct(ook_thd_pct),
        .ask_thd_pct(ask_thd_pct), .agc_linked(agc_linked), .channel_sum(channel_sum),
        .coll_from_slicer(coll_from_slicer), .coll_thd_pct(coll_thd_pct),
        .phase_hold(phase_hold), .start_pulses(start_pulses), .fast_slicer(fast_slicer),
        .ref_tc_long(ref_tc_long), .end_level_pct(end_level_pct),
        .end_detect_en(end_detect_en), .corr_sleep(corr_sleep)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic results();
        if (errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= {24'hFFFFFF, d};
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wait_sleep(input logic lvl);
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (corr_sleep !== lvl && n < 5000);
    endtask

    task automatic check_fields(input logic [7:0] e, input logic [7:0] c, input logic [7:0] s);
        logic       a106;
        logic       bpsk;
        logic [6:0] otc [4] = '{7'd14, 7'd10, 7'd6, 7'd2};
        logic [6:0] atc [4] = '{7'd84, 7'd68, 7'd44, 7'd24};
        logic [6:0] ctl [4] = '{7'd16, 7'd28, 7'd41, 7'd53};
        a106 = std_sel == prc_pkg::STD_ISO_A && rate_106;
        bpsk = (std_sel == prc_pkg::STD_ISO_A && !rate_106) || std_sel == prc_pkg::STD_ISO_B;
        check("ook_tc", ook_tc_tenth_us, otc[e[6:5]]);
        check("ask_tc", ask_tc_tenth_us, atc[e[2:1]]);
        check("ook_thd", ook_thd_pct, e[6:5] == 0 ? 55 - 10 * e[4:3] : 80 - 5 * e[4:3]);
        check("ask_thd", ask_thd_pct, e[0] ? 95 : 97);
        check("fast_decay", onoff_keying_fast_decay, e[7]);
        check("ask_thd_sel", amp_keying_thd_sel, e[0]);
        check("agc_link", agc_linked, c[7]);
        check("coll_src", coll_from_slicer, a106 & c[6]);
        check("phase_hold", phase_hold, bpsk & c[6]);
        check("squelch", squelch_step_select, c[5]);
        check("sum", channel_sum, c[4]);
        check("start", start_pulses, c[3] ? (rate_106 ? 33 : 17) : (rate_106 ? 17 : 9));
        check("fast_slicer", fast_slicer, a106 & c[2]);
        check("ref_tc_long", ref_tc_long, bpsk & c[2]);
        check("coll_thd", coll_thd_pct, ctl[c[1:0]]);
        check("end_level", end_level_pct, c[1] ? 66 : 100);
        check("end_det", end_detect_en, bpsk & c[0]);
        check("stream", subcarrier_stream_mode, s[0]);
    endtask

    initial
    begin
        seed = 32'h769e;
        errors = 0;
        n_tests = 0;
        cycles = 0;
        rst_b = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        byteenable = 4'hF;
        std_sel = prc_pkg::STD_ISO_A;
        rate_106 = 1'b1;
        corr_pulse = 1'b1;
        rx_on = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        bus(1'b0, 8'h2C, 8'h00);
        check("env reset", q, 32'h0C);
        bus(1'b0, 8'h30, 8'h00);
        check("cor1 reset", q, 32'h93);
        bus(1'b0, 8'h34, 8'h00);
        check("cor2 reset", q, 32'h00);
        check_fields(8'h0C, 8'h93, 8'h00);
        for (int k = 0; k < 40; k++)
        begin
            e = 8'($random(seed));
            c = 8'($random(seed));
            s = 8'($random(seed));
            if (k < 4)
            begin
                e = {k[0], k[1:0], k[1:0], k[1:0], k[0]};
                c = {4{k[1:0]}};
            end
            s[0] = (k % 6 == 4);
            std_sel <= prc_pkg::prc_std_e'(3'(k % 6));
            rate_106 <= 1'($random(seed));
            corr_pulse <= 1'($random(seed));
            rx_on <= 1'($random(seed));
            bus(1'b1, 8'h2C, e);
            bus(1'b1, 8'h30, c);
            bus(1'b1, 8'h34, s);
            bus(1'b0, 8'h2F, 8'h00);
            check("env", q, {24'h0, e});
            bus(1'b0, 8'h30, 8'h00);
            check("cor1", q, {24'h0, c});
            bus(1'b0, 8'h34, 8'h00);
            check("cor2", q, {30'h0, s[1:0]});
            check_fields(e, c, s);
        end
        bus(1'b1, 8'h38, 8'h5A);
        bus(1'b0, 8'h38, 8'h00);
        check("unmapped", q, 32'h0);
        byteenable <= 4'hE;
        bus(1'b1, 8'h30, ~c);
        byteenable <= 4'hF;
        bus(1'b0, 8'h30, 8'h00);
        check("lane off", q, {24'h0, c});
        std_sel <= prc_pkg::STD_ISO_A;
        rx_on <= 1'b0;
        corr_pulse <= 1'b1;
        bus(1'b1, 8'h34, 8'h00);
        corr_pulse <= 1'b0;
        wait_sleep(1'b1);
        check("sleep entry", n >= 898 && n <= 904, 1'b1);
        wait_sleep(1'b0);
        check("short wake", n >= 896 && n <= 904, 1'b1);
        std_sel <= prc_pkg::STD_F212;
        wait_sleep(1'b1);
        wait_sleep(1'b0);
        check("long wake", n >= 2096 && n <= 2104, 1'b1);
        bus(1'b1, 8'h34, 8'h02);
        wait_sleep(1'b1);
        repeat (3000) @(posedge ref_clk);
        check("rx only hold", corr_sleep, 1'b1);
        rx_on <= 1'b1;
        wait_sleep(1'b0);
        check("rx wake", n <= 3, 1'b1);
        results();
    end
endmodule

bind prc_cfg_regs prc_cfg_checker u_chk
(
    .ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .std_sel(std_sel),
    .rate_106(rate_106), .corr_pulse(corr_pulse), .ook_tc_tenth_us(ook_tc_tenth_us),
    .ook_thd_pct(ook_thd_pct), .coll_from_slicer(coll_from_slicer),
    .start_pulses(start_pulses), .end_detect_en(end_detect_en), .corr_sleep(corr_sleep)
);
